// [hw/iofil_pkg.sv]
// Constants for the input filter, event and lock block
package iofil_pkg;
   localparam int          IOFIL_LINES = 32;
   localparam int          IOFIL_AW    = 8;
   localparam int          IOFIL_DIVW  = 14;
   // ==========================================================
   // Register offsets
   localparam logic [7:0]  IOFIL_CTRL_EN    = 8'h00;
   localparam logic [7:0]  IOFIL_CTRL_DIS   = 8'h04;
   localparam logic [7:0]  IOFIL_CTRL_ST    = 8'h08;
   localparam logic [7:0]  IOFIL_FILT_EN    = 8'h20;
   localparam logic [7:0]  IOFIL_FILT_DIS   = 8'h24;
   localparam logic [7:0]  IOFIL_FILT_ST    = 8'h28;
   localparam logic [7:0]  IOFIL_PIN_LEVEL  = 8'h3C;
   localparam logic [7:0]  IOFIL_IRQ_EN     = 8'h40;
   localparam logic [7:0]  IOFIL_IRQ_DIS    = 8'h44;
   localparam logic [7:0]  IOFIL_IRQ_MASK   = 8'h48;
   localparam logic [7:0]  IOFIL_IRQ_EVT    = 8'h4C;
   localparam logic [7:0]  IOFIL_MD_EN      = 8'h50;
   localparam logic [7:0]  IOFIL_MD_DIS     = 8'h54;
   localparam logic [7:0]  IOFIL_MD_ST      = 8'h58;
   localparam logic [7:0]  IOFIL_PU_DIS     = 8'h60;
   localparam logic [7:0]  IOFIL_PU_EN      = 8'h64;
   localparam logic [7:0]  IOFIL_PU_ST      = 8'h68;
   localparam logic [7:0]  IOFIL_PERIPH_SEL = 8'h70;
   localparam logic [7:0]  IOFIL_GLITCH_SEL = 8'h80;
   localparam logic [7:0]  IOFIL_DEB_SEL    = 8'h84;
   localparam logic [7:0]  IOFIL_KIND_ST    = 8'h88;
   localparam logic [7:0]  IOFIL_SLOW_DIV   = 8'h8C;
   localparam logic [7:0]  IOFIL_XMODE_EN   = 8'hB0;
   localparam logic [7:0]  IOFIL_XMODE_DIS  = 8'hB4;
   localparam logic [7:0]  IOFIL_XMODE_MASK = 8'hB8;
   localparam logic [7:0]  IOFIL_EDGE_SEL   = 8'hC0;
   localparam logic [7:0]  IOFIL_LEVEL_SEL  = 8'hC4;
   localparam logic [7:0]  IOFIL_EL_ST      = 8'hC8;
   localparam logic [7:0]  IOFIL_FALL_SEL   = 8'hD0;
   localparam logic [7:0]  IOFIL_RISE_SEL   = 8'hD4;
   localparam logic [7:0]  IOFIL_POL_ST     = 8'hD8;
   localparam logic [7:0]  IOFIL_LOCK_ST    = 8'hE0;
   // ==========================================================
   // Reset values
   localparam logic [31:0] IOFIL_ZERO       = 32'h00000000;
   localparam logic [31:0] IOFIL_CTRL_RST   = 32'hFFFFFFFF;
   localparam logic [IOFIL_DIVW-1:0] IOFIL_DIV_RST = 14'h0000;
endpackage : iofil_pkg

// [hw/iofil_slowdiv.sv]
// Divided slow clock: half-period tick generator
`timescale 1ns/1ps
`default_nettype none
module iofil_slowdiv
   import iofil_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  rst_sync_b,
   input  wire logic                  run,
   input  wire logic                  slow_lvl,
   input  wire logic [IOFIL_DIVW-1:0] div,
   output logic                      half_tick
);
   import iofil_pkg::*;

   typedef struct packed {
      logic                  slow_prev;
      logic [IOFIL_DIVW-1:0] cnt;
      logic                  tick;
   } iofil_div_t;

   iofil_div_t st;
   iofil_div_t next_st;

   // ==========================================================
   // Tick every DIV+1 rising slow edges, so full period is (DIV+1)*2
   always_comb begin
      next_st           = st;
      next_st.tick      = 1'b0;
      next_st.slow_prev = slow_lvl;
      if (run && slow_lvl && !st.slow_prev) begin
         if (st.cnt >= div) begin
            next_st.cnt  = '0;
            next_st.tick = 1'b1;
         end else begin
            next_st.cnt = st.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign half_tick = st.tick;
endmodule : iofil_slowdiv
`default_nettype wire

// [hw/iofil_filter.sv]
// Per-line glitch and debounce input filters
`timescale 1ns/1ps
`default_nettype none
module iofil_filter
   import iofil_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_sync_b,
   input  wire logic        run,
   input  wire logic        half_tick,
   input  wire logic [31:0] raw,
   input  wire logic [31:0] enable,
   input  wire logic [31:0] kind,
   output logic [31:0]      filtered
);
   import iofil_pkg::*;

   typedef struct packed {
      logic [31:0] out;
      logic [31:0] gprev;
      logic [31:0] dprev;
   } iofil_flt_t;

   iofil_flt_t  st;
   iofil_flt_t  next_st;
   logic [31:0] next_out;
   logic [31:0] next_dprev;

   // ==========================================================
   // On lines with the filter enabled, a change is accepted only when two successive samples agree
   genvar i;
   generate
      for (i = 0; i < IOFIL_LINES; i++) begin : g_line
         always_comb begin
            next_out[i]   = st.out[i];
            next_dprev[i] = st.dprev[i];
            if (run) begin
               if (!enable[i]) begin
                  next_out[i] = raw[i];
               end else if (!kind[i]) begin
                  if (raw[i] == st.gprev[i]) begin
                     next_out[i] = raw[i];
                  end
               end else if (half_tick) begin
                  next_dprev[i] = raw[i];
                  if (raw[i] == st.dprev[i]) begin
                     next_out[i] = raw[i];
                  end
               end
            end
         end
      end
   endgenerate

   always_comb begin
      next_st       = st;
      next_st.out   = next_out;
      next_st.dprev = next_dprev;
      if (run) begin
         next_st.gprev = raw;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign filtered = st.out;
endmodule : iofil_filter
`default_nettype wire

// [hw/iofil_top.sv]
// Input filtering, edge/level events, interrupt and line lock
// ==========================================================
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module iofil_top
   import iofil_pkg::*;
(
   input  wire logic                clk_sys,
   input  wire logic                rst_b,
   input  wire logic                ctrl_clk_en,
   input  wire logic [31:0]         pin_in,
   input  wire logic                slow_clk_in,
   input  wire logic [31:0]         periph_lock,
   input  wire logic [IOFIL_AW-1:0] reg_addr,
   input  wire logic [31:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [31:0]              reg_rdata,
   output logic [31:0]              periph_in,
   output logic [31:0]              ctrl_owns,
   output logic [31:0]              multidrive,
   output logic [31:0]              pullup_off,
   output logic [31:0]              periph_b_sel,
   output logic                     irq
);
   import iofil_pkg::*;

   typedef struct packed {
      logic [31:0]           pin_m;
      logic [31:0]           pin_s;
      logic                  slow_m;
      logic                  slow_s;
      logic [31:0]           ctrl_st;
      logic [31:0]           md_st;
      logic [31:0]           pu_st;
      logic [31:0]           absel;
      logic [31:0]           filt_st;
      logic [31:0]           kind_st;
      logic [IOFIL_DIVW-1:0] div;
      logic [31:0]           imask;
      logic [31:0]           ievt;
      logic [31:0]           xmode;
      logic [31:0]           elsel;
      logic [31:0]           polsel;
      logic [31:0]           lock;
      logic [31:0]           fprev;
      logic [31:0]           rdata;
   } iofil_st_t;

   iofil_st_t   st;
   iofil_st_t   next_st;
   logic [1:0]  rst_pipe;
   logic        rst_sync_b;
   logic        half_tick;
   logic [31:0] filtered;
   logic [31:0] rise;
   logic [31:0] fall;
   logic [31:0] event_hit;
   logic [31:0] wmask;
   logic [31:0] rd_val;

   // ==========================================================
   // Reset release
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_sync_b = rst_pipe[1];

   // ==========================================================
   // Slow clock divider and filters
   iofil_slowdiv u_div (
      .clk_sys    (clk_sys),
      .rst_sync_b (rst_sync_b),
      .run        (ctrl_clk_en),
      .slow_lvl   (st.slow_s),
      .div        (st.div),
      .half_tick  (half_tick)
   );

   iofil_filter u_flt (
      .clk_sys    (clk_sys),
      .rst_sync_b (rst_sync_b),
      .run        (ctrl_clk_en),
      .half_tick  (half_tick),
      .raw        (st.pin_s),
      .enable     (st.filt_st),
      .kind       (st.kind_st),
      .filtered   (filtered)
   );

   // ==========================================================
   // Event detection
   always_comb begin
      rise = filtered & ~st.fprev;
      fall = ~filtered & st.fprev;
      for (int k = 0; k < IOFIL_LINES; k++) begin
         if (!st.xmode[k]) begin
            event_hit[k] = rise[k] | fall[k];
         end else if (!st.elsel[k]) begin
            event_hit[k] = st.polsel[k] ? rise[k] : fall[k];
         end else begin
            event_hit[k] = st.polsel[k] ? filtered[k] : ~filtered[k];
         end
      end
      if (!ctrl_clk_en) begin
         event_hit = '0;
      end
   end

   // ==========================================================
   // Read mux
   always_comb begin
      rd_val = IOFIL_ZERO;
      if (reg_addr == IOFIL_CTRL_ST) begin
         rd_val = st.ctrl_st;
      end else if (reg_addr == IOFIL_FILT_ST) begin
         rd_val = st.filt_st;
      end else if (reg_addr == IOFIL_PIN_LEVEL) begin
         rd_val = filtered;
      end else if (reg_addr == IOFIL_IRQ_MASK) begin
         rd_val = st.imask;
      end else if (reg_addr == IOFIL_IRQ_EVT) begin
         rd_val = st.ievt;
      end else if (reg_addr == IOFIL_MD_ST) begin
         rd_val = st.md_st;
      end else if (reg_addr == IOFIL_PU_ST) begin
         rd_val = st.pu_st;
      end else if (reg_addr == IOFIL_PERIPH_SEL) begin
         rd_val = st.absel;
      end else if (reg_addr == IOFIL_KIND_ST) begin
         rd_val = st.kind_st;
      end else if (reg_addr == IOFIL_SLOW_DIV) begin
         rd_val = {{(32 - IOFIL_DIVW){1'b0}}, st.div};
      end else if (reg_addr == IOFIL_XMODE_MASK) begin
         rd_val = st.xmode;
      end else if (reg_addr == IOFIL_EL_ST) begin
         rd_val = st.elsel;
      end else if (reg_addr == IOFIL_POL_ST) begin
         rd_val = st.polsel;
      end else if (reg_addr == IOFIL_LOCK_ST) begin
         rd_val = st.lock;
      end
   end

   // ==========================================================
   // State update
   always_comb begin
      next_st        = st;
      next_st.pin_m  = pin_in;
      next_st.pin_s  = st.pin_m;
      next_st.slow_m = slow_clk_in;
      next_st.slow_s = st.slow_m;
      next_st.rdata  = reg_rd ? rd_val : IOFIL_ZERO;
      next_st.lock   = st.lock | periph_lock;
      if (ctrl_clk_en) begin
         next_st.fprev = filtered;
      end
      wmask = reg_wdata & ~st.lock;
      if (reg_wr) begin
         if (reg_addr == IOFIL_CTRL_EN) begin
            next_st.ctrl_st = st.ctrl_st | wmask;
         end else if (reg_addr == IOFIL_CTRL_DIS) begin
            next_st.ctrl_st = st.ctrl_st & ~wmask;
         end else if (reg_addr == IOFIL_MD_EN) begin
            next_st.md_st = st.md_st | wmask;
         end else if (reg_addr == IOFIL_MD_DIS) begin
            next_st.md_st = st.md_st & ~wmask;
         end else if (reg_addr == IOFIL_PU_DIS) begin
            next_st.pu_st = st.pu_st | wmask;
         end else if (reg_addr == IOFIL_PU_EN) begin
            next_st.pu_st = st.pu_st & ~wmask;
         end else if (reg_addr == IOFIL_PERIPH_SEL) begin
            next_st.absel = (st.absel & st.lock) | wmask;
         end else if (reg_addr == IOFIL_FILT_EN) begin
            next_st.filt_st = st.filt_st | reg_wdata;
         end else if (reg_addr == IOFIL_FILT_DIS) begin
            next_st.filt_st = st.filt_st & ~reg_wdata;
         end else if (reg_addr == IOFIL_GLITCH_SEL) begin
            next_st.kind_st = st.kind_st & ~reg_wdata;
         end else if (reg_addr == IOFIL_DEB_SEL) begin
            next_st.kind_st = st.kind_st | reg_wdata;
         end else if (reg_addr == IOFIL_SLOW_DIV) begin
            next_st.div = reg_wdata[IOFIL_DIVW-1:0];
         end else if (reg_addr == IOFIL_IRQ_EN) begin
            next_st.imask = st.imask | reg_wdata;
         end else if (reg_addr == IOFIL_IRQ_DIS) begin
            next_st.imask = st.imask & ~reg_wdata;
         end else if (reg_addr == IOFIL_XMODE_EN) begin
            next_st.xmode = st.xmode | reg_wdata;
         end else if (reg_addr == IOFIL_XMODE_DIS) begin
            next_st.xmode = st.xmode & ~reg_wdata;
         end else if (reg_addr == IOFIL_EDGE_SEL) begin
            next_st.elsel = st.elsel & ~reg_wdata;
         end else if (reg_addr == IOFIL_LEVEL_SEL) begin
            next_st.elsel = st.elsel | reg_wdata;
         end else if (reg_addr == IOFIL_FALL_SEL) begin
            next_st.polsel = st.polsel & ~reg_wdata;
         end else if (reg_addr == IOFIL_RISE_SEL) begin
            next_st.polsel = st.polsel | reg_wdata;
         end
      end
      // Read clears, a same-cycle event still sets
      if (reg_rd && reg_addr == IOFIL_IRQ_EVT) begin
         next_st.ievt = event_hit;
      end else begin
         next_st.ievt = st.ievt | event_hit;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         st         <= '0;
         st.ctrl_st <= IOFIL_CTRL_RST;
         st.div     <= IOFIL_DIV_RST;
         st.elsel   <= IOFIL_ZERO;
         st.polsel  <= IOFIL_ZERO;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Outputs
   assign reg_rdata    = st.rdata;
   assign periph_in    = st.pin_s;
   assign ctrl_owns    = st.ctrl_st;
   assign multidrive   = st.md_st;
   assign pullup_off   = st.pu_st;
   assign periph_b_sel = st.absel;
   assign irq          = |(st.ievt & st.imask);
endmodule : iofil_top
`default_nettype wire

// [test/iofil_top_asserts.sv]
// Checker for the filter, event and lock block
`timescale 1ns/1ps
`default_nettype none
module iofil_top_asserts
   import iofil_pkg::*;
(
   input wire logic                clk_sys,
   input wire logic                rst_b,
   input wire logic                ctrl_clk_en,
   input wire logic [31:0]         pin_in,
   input wire logic                slow_clk_in,
   input wire logic [31:0]         periph_lock,
   input wire logic [IOFIL_AW-1:0] reg_addr,
   input wire logic [31:0]         reg_wdata,
   input wire logic                reg_wr,
   input wire logic                reg_rd,
   input wire logic [31:0]         reg_rdata,
   input wire logic [31:0]         periph_in,
   input wire logic [31:0]         ctrl_owns,
   input wire logic [31:0]         multidrive,
   input wire logic [31:0]         pullup_off,
   input wire logic [31:0]         periph_b_sel,
   input wire logic                irq
);
   // ==========
   // Shadow state
   localparam logic [7:0] GRP [6] = '{IOFIL_FILT_EN, IOFIL_IRQ_EN, IOFIL_XMODE_EN,
                                      IOFIL_GLITCH_SEL, IOFIL_EDGE_SEL, IOFIL_FALL_SEL};
   logic [31:0] sh [6];
   logic [31:0] lock_sh;
   logic [31:0] exp_st;
   logic [31:0] free;
   logic        hit;
   logic [2:0]  cnt;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sh      <= '{default: 32'h00000000};
         lock_sh <= 32'h00000000;
         cnt     <= 3'h0;
      end else begin
         lock_sh <= lock_sh | periph_lock;
         if (cnt != 3'h7) cnt <= cnt + 3'h1;
         for (int i = 0; i < 6; i++) begin
            if (reg_wr && reg_addr == GRP[i] + (i < 3 ? 8'h00 : 8'h04)) sh[i] <= sh[i] | reg_wdata;
            if (reg_wr && reg_addr == GRP[i] + (i < 3 ? 8'h04 : 8'h00)) sh[i] <= sh[i] & ~reg_wdata;
         end
      end
   end
   always_comb begin
      hit    = 1'b0;
      exp_st = 32'h00000000;
      for (int i = 0; i < 6; i++) begin
         if (reg_addr == GRP[i] + 8'h08) begin
            hit    = 1'b1;
            exp_st = sh[i];
         end
      end
   end
   assign free = reg_wdata & ~lock_sh & ~periph_lock;
   // ==========
   // Properties
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   sequence frozen_s;
      !ctrl_clk_en [*3];
   endsequence
   sequence rd_frozen_s;
      reg_rd && reg_addr == IOFIL_IRQ_EVT && !ctrl_clk_en;
   endsequence
   shadow_read_a: assert property (reg_rd && hit |=> reg_rdata == $past(exp_st))
      else $error("status readback differs from written selections");
   periph_raw_a: assert property (cnt == 3'h7 && $past(ctrl_clk_en) && $past(ctrl_clk_en, 2) |-> periph_in == $past(pin_in, 2))
      else $error("peripheral input not the plain synced pin");
   lock_keep_a: assert property ((((ctrl_owns ^ $past(ctrl_owns)) | (multidrive ^ $past(multidrive))
      | (pullup_off ^ $past(pullup_off)) | (periph_b_sel ^ $past(periph_b_sel))) & $past(lock_sh)) == 32'h00000000)
      else $error("locked line configuration changed");
   lock_read_a: assert property (reg_rd && reg_addr == IOFIL_LOCK_ST |=> reg_rdata == $past(lock_sh))
      else $error("lock status differs from lock requests");
   no_mask_irq_a: assert property (sh[1] == 32'h00000000 && $past(sh[1]) == 32'h00000000 |-> !irq)
      else $error("interrupt raised with all lines masked");
   isr_clear_a: assert property (frozen_s ##1 rd_frozen_s ##1 rd_frozen_s |=> reg_rdata == 32'h00000000)
      else $error("event status not cleared by read");
   ctrl_clear_a: assert property (reg_wr && reg_addr == IOFIL_CTRL_DIS |=> (ctrl_owns & $past(free)) == 32'h00000000)
      else $error("unlocked controller bit not cleared");
   md_set_a: assert property (reg_wr && reg_addr == IOFIL_MD_EN |=> (multidrive & $past(free)) == $past(free))
      else $error("unlocked multidrive bit not set");
endmodule // iofil_top_asserts
bind iofil_top iofil_top_asserts iofil_top_asserts_inst (.clk_sys, .rst_b, .ctrl_clk_en, .pin_in, .slow_clk_in,
   .periph_lock, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .periph_in, .ctrl_owns, .multidrive,
   .pullup_off, .periph_b_sel, .irq);
`default_nettype wire

// [test/iofil_pins.sv]
// Model of the pins and the free-running slow clock
`timescale 1ns/1ps
`default_nettype none
module iofil_pins #(
   parameter int SLOW_HALF_NS = 213
) (
   input  wire logic [31:0] lvl,
   output logic [31:0]      pin_in,
   output logic             slow_clk_in
);
   logic [31:0] flip;
   initial begin
      flip        = 32'h00000000;
      slow_clk_in = 1'b0;
   end
   // Slow clock, unrelated in phase to the system clock
   always #(SLOW_HALF_NS) slow_clk_in = ~slow_clk_in;
   assign pin_in = lvl ^ flip;
   // Short pulse on one line, any length in ns
   task automatic pulse(input int idx, input int ns);
      flip[idx] = 1'b1;
      #(ns);
      flip[idx] = 1'b0;
   endtask
endmodule // iofil_pins
`default_nettype wire

// [test/tb_iofil_top.sv]
// Testbench for the filter, event and lock block
`timescale 1ns/1ps
`default_nettype none
module tb_iofil_top;
   import iofil_pkg::*;
   logic                clk_sys = 1'b0;
   logic                rst_b = 1'b0;
   logic                ctrl_clk_en = 1'b1;
   logic [31:0]         lvl = 32'h00000000;
   logic [31:0]         periph_lock = 32'h00000000;
   logic [IOFIL_AW-1:0] reg_addr = 8'h00;
   logic [31:0]         reg_wdata = 32'h00000000;
   logic                reg_wr = 1'b0;
   logic                reg_rd = 1'b0;
   logic [31:0]         pin_in, reg_rdata, periph_in, ctrl_owns, multidrive, pullup_off, periph_b_sel;
   logic                slow_clk_in, irq;
   int                  n_fail = 0;
   int                  checks = 0;
   always #25 clk_sys = ~clk_sys;
   iofil_pins iofil_pins_inst (.lvl, .pin_in, .slow_clk_in);
   iofil_top iofil_top_inst (.clk_sys, .rst_b, .ctrl_clk_en, .pin_in, .slow_clk_in, .periph_lock, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .periph_in, .ctrl_owns, .multidrive, .pullup_off, .periph_b_sel, .irq);
   // ==========
   // Bus and compare tasks
   task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1;
      cmp($sformatf("reg %h", a), e, reg_rdata & m);
   endtask
   task automatic rd2(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e1, input logic [31:0] e2);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      #1;
      cmp("first read", e1, reg_rdata & m);
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      cmp("second read", e2, reg_rdata & m);
   endtask
   task automatic pin(input int i, input logic v);
      @(posedge clk_sys);
      lvl[i] <= v;
      cyc(10);
   endtask
   task automatic glitch(input int w);
      @(negedge clk_sys);
      #15;
      iofil_pins_inst.pulse(3, w);
      cyc(10);
   endtask
   // ==========
   // Scenarios
   task automatic t_reset();
      logic [7:0] a [13] = '{IOFIL_CTRL_ST, IOFIL_FILT_ST, IOFIL_IRQ_MASK, IOFIL_MD_ST, IOFIL_PU_ST, IOFIL_PERIPH_SEL,
         IOFIL_KIND_ST, IOFIL_SLOW_DIV, IOFIL_XMODE_MASK, IOFIL_EL_ST, IOFIL_POL_ST, IOFIL_LOCK_ST, 8'h0C};
      for (int i = 0; i < 13; i++) rd(a[i], 32'hFFFFFFFF, i == 0 ? IOFIL_CTRL_RST : IOFIL_ZERO);
      $display("t_reset done");
   endtask
   task automatic t_regs();
      logic [7:0] s [9] = '{IOFIL_CTRL_EN, IOFIL_FILT_EN, IOFIL_IRQ_EN, IOFIL_MD_EN, IOFIL_PU_DIS, IOFIL_XMODE_EN,
         IOFIL_DEB_SEL, IOFIL_LEVEL_SEL, IOFIL_RISE_SEL};
      logic [7:0] c [9] = '{IOFIL_CTRL_DIS, IOFIL_FILT_DIS, IOFIL_IRQ_DIS, IOFIL_MD_DIS, IOFIL_PU_EN, IOFIL_XMODE_DIS,
         IOFIL_GLITCH_SEL, IOFIL_EDGE_SEL, IOFIL_FALL_SEL};
      for (int i = 0; i < 9; i++) begin
         wr(s[i], 32'h0000FF0F);
         wr(c[i], 32'h0000000F);
         rd(i < 6 ? s[i] + 8'h08 : c[i] + 8'h08, 32'hFFFFFFFF, i == 0 ? 32'hFFFFFFF0 : 32'h0000FF00);
         wr(i == 0 ? s[i] : c[i], 32'hFFFFFFFF);
      end
      $display("t_regs done");
   endtask
   task automatic t_events();
      rd(IOFIL_IRQ_EVT, 32'hFFFFFFFF, 32'h00000000);
      wr(IOFIL_IRQ_EN, 32'h00000001);
      pin(0, 1'b1);
      cmp("irq", 32'h00000001, {31'h00000000, irq});
      rd2(IOFIL_IRQ_EVT, 32'h00000001, 32'h00000001, 32'h00000000);
      cmp("irq", 32'h00000000, {31'h00000000, irq});
      pin(0, 1'b0);
      rd(IOFIL_IRQ_EVT, 32'h00000001, 32'h00000001);
      wr(IOFIL_IRQ_DIS, 32'hFFFFFFFF);
      wr(IOFIL_XMODE_EN, 32'h00000006);
      wr(IOFIL_LEVEL_SEL, 32'h00000002);
      wr(IOFIL_RISE_SEL, 32'h00000002);
      pin(1, 1'b1);
      rd2(IOFIL_IRQ_EVT, 32'h00000002, 32'h00000002, 32'h00000002);
      pin(1, 1'b0);
      rd2(IOFIL_IRQ_EVT, 32'h00000002, 32'h00000002, 32'h00000000);
      wr(IOFIL_FALL_SEL, 32'h00000002);
      rd2(IOFIL_IRQ_EVT, 32'h00000002, 32'h00000002, 32'h00000002);
      wr(IOFIL_XMODE_DIS, 32'h00000002);
      pin(2, 1'b1);
      rd(IOFIL_IRQ_EVT, 32'h00000004, 32'h00000000);
      pin(2, 1'b0);
      rd(IOFIL_IRQ_EVT, 32'h00000004, 32'h00000004);
      wr(IOFIL_RISE_SEL, 32'h00000004);
      pin(2, 1'b1);
      rd(IOFIL_IRQ_EVT, 32'h00000004, 32'h00000004);
      pin(2, 1'b0);
      rd(IOFIL_IRQ_EVT, 32'h00000004, 32'h00000000);
      cmp("irq", 32'h00000000, {31'h00000000, irq});
      $display("t_events done");
   endtask
   task automatic t_filters();
      glitch(20);
      rd(IOFIL_IRQ_EVT, 32'h00000008, 32'h00000008);
      wr(IOFIL_FILT_EN, 32'h00000018);
      glitch(20);
      rd(IOFIL_IRQ_EVT, 32'h00000008, 32'h00000000);
      glitch(80);
      rd(IOFIL_IRQ_EVT, 32'h00000008, 32'h00000008);
      wr(IOFIL_SLOW_DIV, 32'h00000001);
      wr(IOFIL_DEB_SEL, 32'h00000010);
      cyc(150);
      rd(IOFIL_IRQ_EVT, 32'hFFFFFFFF, 32'h00000000);
      @(negedge clk_sys);
      iofil_pins_inst.pulse(4, 800);
      cyc(150);
      rd(IOFIL_IRQ_EVT, 32'h00000010, 32'h00000000);
      @(negedge clk_sys);
      iofil_pins_inst.pulse(4, 4000);
      cyc(150);
      rd(IOFIL_IRQ_EVT, 32'h00000010, 32'h00000010);
      $display("t_filters done");
   endtask
   task automatic t_freeze();
      @(posedge clk_sys);
      ctrl_clk_en <= 1'b0;
      pin(5, 1'b1);
      rd2(IOFIL_IRQ_EVT, 32'h00000020, 32'h00000000, 32'h00000000);
      rd(IOFIL_PIN_LEVEL, 32'h00000020, 32'h00000000);
      @(posedge clk_sys);
      ctrl_clk_en <= 1'b1;
      cyc(10);
      rd(IOFIL_IRQ_EVT, 32'h00000020, 32'h00000020);
      rd(IOFIL_PIN_LEVEL, 32'h00000020, 32'h00000020);
      $display("t_freeze done");
   endtask
   task automatic t_lock();
      @(posedge clk_sys);
      periph_lock <= 32'h00000040;
      @(posedge clk_sys);
      periph_lock <= 32'h00000000;
      wr(IOFIL_CTRL_DIS, 32'h000000C0);
      wr(IOFIL_PERIPH_SEL, 32'h000000FF);
      wr(IOFIL_MD_EN, 32'h000000C0);
      rd(IOFIL_CTRL_ST, 32'h000000C0, 32'h00000040);
      cmp("periph_b_sel", 32'h000000BF, periph_b_sel);
      cmp("multidrive", 32'h00000080, multidrive);
      rd(IOFIL_LOCK_ST, 32'hFFFFFFFF, 32'h00000040);
      @(posedge clk_sys);
      rst_b <= 1'b0;
      cyc(3);
      rst_b <= 1'b1;
      cyc(3);
      rd(IOFIL_LOCK_ST, 32'hFFFFFFFF, 32'h00000000);
      $display("t_lock done");
   endtask
   // ==========
   // Run control
   task automatic end_of_test();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      cyc(3);
      t_reset();
      t_regs();
      t_events();
      t_filters();
      t_freeze();
      t_lock();
      end_of_test();
   end
   initial begin
      #1000000;
      n_fail++;
      end_of_test();
   end
endmodule // tb_iofil_top
`default_nettype wire
